// [rtl/swdt_consts.svh]
// Purpose: offsets, fields, reset values and timing counts of the system watchdog
// Assumes: 25 MHz clock, Avalon-MM word addressing of 32-bit registers
// Notes:   definitions only
`ifndef SWDT_CONSTS_SVH
`define SWDT_CONSTS_SVH

`define SWDT_CLK_HZ         25000000
`define SWDT_SEC_NS         1000000000
`define SWDT_CLK_NS         40
`define SWDT_SEC_CYCLES     (`SWDT_SEC_NS / `SWDT_CLK_NS)
`define SWDT_MIN_SECONDS    60
`define SWDT_FLASH_SECONDS  1

`define SWDT_ADDR_CMD       4'h0
`define SWDT_ADDR_TIMEOUT   4'h1
`define SWDT_ADDR_STATUS    4'h2
`define SWDT_ADDR_IRQ_STAT  4'h3
`define SWDT_ADDR_IRQ_MASK  4'h4
`define SWDT_ADDR_COUNT     4'h5

`define SWDT_CMD_INIT       3'h1
`define SWDT_CMD_SET        3'h2
`define SWDT_CMD_START      3'h3
`define SWDT_CMD_RELOAD     3'h4
`define SWDT_CMD_STOP       3'h5

`define SWDT_UNIT_SEC       8'h00
`define SWDT_UNIT_MIN       8'h01

`define SWDT_IRQ_FAIL_BIT   0
`define SWDT_IRQ_EXPIRE_BIT 1
`define SWDT_IRQ_WIDTH      2

`define SWDT_RST_TICKS      8'h01
`define SWDT_RST_PULSE      16'h0010

`endif

// [rtl/swdt_pkg.sv]
// Purpose: shared types of the system watchdog
// Assumes: constants live in swdt_consts.svh
// Notes:   no logic here
package swdt_pkg;

  typedef enum logic [1:0] {
    SWDT_ST_IDLE  = 2'b00,
    SWDT_ST_READY = 2'b01,
    SWDT_ST_RUN   = 2'b10,
    SWDT_ST_FIRED = 2'b11
  } swdt_state_t;

  typedef struct packed {
    logic [7:0] ticks;
    logic       minutes;
  } swdt_timeout_t;

  typedef struct packed {
    logic       init_done;
    logic       running;
    logic       last_ok;
    logic       fired;
  } swdt_status_t;

endpackage

// [rtl/swdt_timebase.sv]
// Purpose: one-second enable pulse from the system clock
// Assumes: clock at 25 MHz
// Notes:   restarts on clear so a fresh countdown gets full seconds
`include "swdt_consts.svh"
`timescale 1ns/1ns
module swdt_timebase #(
  parameter int unsigned SEC_CYCLES = `SWDT_SEC_CYCLES
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // control
  input  wire logic clear_i,
  output logic      sec_o
);

  logic [31:0] cnt;
  logic [31:0] next_cnt;
  logic        next_sec;

  always_comb begin
    next_cnt = cnt + 32'h0000_0001;
    next_sec = 1'b0;
    if (clear_i) begin
      next_cnt = 32'h0000_0000;
    end else if (cnt == 32'(SEC_CYCLES - 1)) begin
      next_cnt = 32'h0000_0000;
      next_sec = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt   <= 32'h0000_0000;
      sec_o <= 1'b0;
    end else begin
      cnt   <= next_cnt;
      sec_o <= next_sec;
    end
  end

endmodule // swdt_timebase

// [rtl/swdt_top.sv]
// Purpose: system watchdog with command register, countdown and system reset output
// Assumes: Avalon-MM slave, word addresses, one waitrequest cycle on every access
// Notes:   commands are written to the command register; outcome shows in status
`include "swdt_consts.svh"
`timescale 1ns/1ns
module swdt_top #(
  parameter int unsigned SEC_CYCLES  = `SWDT_SEC_CYCLES,
  parameter int unsigned MIN_SECONDS = `SWDT_MIN_SECONDS
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // avalon-mm slave
  input  wire logic [3:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  // system side
  output logic             sys_reset_o,
  output logic             led_o,
  output logic             irq_o
);

  swdt_pkg::swdt_state_t   state;
  swdt_pkg::swdt_state_t   next_state;
  swdt_pkg::swdt_timeout_t timeout;
  swdt_pkg::swdt_timeout_t next_timeout;
  logic [7:0]  ticks_left;
  logic [7:0]  next_ticks_left;
  logic [5:0]  secs_left;
  logic [5:0]  next_secs_left;
  logic        last_ok;
  logic        next_last_ok;
  logic [15:0] rst_cnt;
  logic [15:0] next_rst_cnt;
  logic [1:0]  irq_stat;
  logic [1:0]  next_irq_stat;
  logic [1:0]  irq_mask;
  logic [1:0]  next_irq_mask;
  logic        led;
  logic        next_led;
  logic        served;
  logic        next_served;
  logic [31:0] next_rdata;
  logic        sec_tick;
  logic        tb_clear;
  logic        cmd_we;
  logic [2:0]  cmd;
  logic        ev_fail;
  logic        ev_expire;

  // seconds per tick minus one for the chosen unit
  function automatic logic [5:0] unit_secs(input logic minutes);
    unit_secs = minutes ? 6'(MIN_SECONDS - 1) : 6'h00;
  endfunction

  // answer on the second cycle: waitrequest high in the request cycle
  assign cmd_we = avs_write_i && served && (avs_address_i == `SWDT_ADDR_CMD);
  assign cmd    = avs_writedata_i[2:0];

  swdt_timebase #(
    .SEC_CYCLES (SEC_CYCLES)
  ) u_timebase (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .clear_i (tb_clear),
    .sec_o   (sec_tick)
  );

  always_comb begin
    next_state      = state;
    next_timeout    = timeout;
    next_ticks_left = ticks_left;
    next_secs_left  = secs_left;
    next_last_ok    = last_ok;
    next_rst_cnt    = rst_cnt;
    next_led        = led;
    tb_clear        = 1'b0;
    ev_fail         = 1'b0;
    ev_expire       = 1'b0;
    if (cmd_we) begin
      next_last_ok = 1'b1;
      if (state == swdt_pkg::SWDT_ST_IDLE && cmd != `SWDT_CMD_INIT) begin
        next_last_ok = 1'b0;
      end else begin
        unique case (cmd)
          `SWDT_CMD_INIT: begin
            if (state == swdt_pkg::SWDT_ST_IDLE) begin
              next_state = swdt_pkg::SWDT_ST_READY;
            end
          end
          `SWDT_CMD_SET: begin
            if (avs_writedata_i[15:8] == 8'h00 ||
                (avs_writedata_i[23:16] != `SWDT_UNIT_SEC &&
                 avs_writedata_i[23:16] != `SWDT_UNIT_MIN)) begin
              next_last_ok = 1'b0;
            end else begin
              next_timeout.ticks   = avs_writedata_i[15:8];
              next_timeout.minutes = avs_writedata_i[16];
            end
          end
          `SWDT_CMD_START, `SWDT_CMD_RELOAD: begin
            if (cmd == `SWDT_CMD_RELOAD && state != swdt_pkg::SWDT_ST_RUN) begin
              next_last_ok = 1'b0;
            end else begin
              next_state      = swdt_pkg::SWDT_ST_RUN;
              next_ticks_left = timeout.ticks;
              next_secs_left  = unit_secs(timeout.minutes);
              tb_clear        = 1'b1;
            end
          end
          `SWDT_CMD_STOP: begin
            if (state == swdt_pkg::SWDT_ST_RUN) begin
              next_state = swdt_pkg::SWDT_ST_READY;
            end
            next_led = 1'b0;
          end
          default: begin
            next_last_ok = 1'b0;
          end
        endcase
      end
      ev_fail = !next_last_ok;
    end else if (state == swdt_pkg::SWDT_ST_RUN && sec_tick) begin
      next_led = !led;
      if (secs_left != 6'h00) begin
        next_secs_left = secs_left - 6'h01;
      end else if (ticks_left != `SWDT_RST_TICKS) begin
        next_ticks_left = ticks_left - 8'h01;
        next_secs_left  = unit_secs(timeout.minutes);
      end else begin
        next_state   = swdt_pkg::SWDT_ST_FIRED;
        next_rst_cnt = `SWDT_RST_PULSE;
        next_led     = 1'b0;
        ev_expire    = 1'b1;
      end
    end else if (state == swdt_pkg::SWDT_ST_FIRED) begin
      if (rst_cnt != 16'h0000) begin
        next_rst_cnt = rst_cnt - 16'h0001;
      end else begin
        next_state = swdt_pkg::SWDT_ST_READY;
      end
    end
  end

  always_comb begin
    next_served   = (avs_read_i || avs_write_i) && !served;
    next_irq_mask = irq_mask;
    next_irq_stat = irq_stat;
    // hold the last answer until the next read is served
    next_rdata    = avs_readdata_o;
    if (avs_write_i && served && avs_address_i == `SWDT_ADDR_IRQ_MASK) begin
      next_irq_mask = avs_writedata_i[1:0];
    end
    if (avs_write_i && served && avs_address_i == `SWDT_ADDR_IRQ_STAT) begin
      next_irq_stat = irq_stat & ~avs_writedata_i[1:0];
    end
    // set wins over clear
    next_irq_stat[`SWDT_IRQ_FAIL_BIT]   = next_irq_stat[`SWDT_IRQ_FAIL_BIT] | ev_fail;
    next_irq_stat[`SWDT_IRQ_EXPIRE_BIT] = next_irq_stat[`SWDT_IRQ_EXPIRE_BIT] | ev_expire;
    if (avs_read_i && !served) begin
      unique case (avs_address_i)
        `SWDT_ADDR_TIMEOUT:  next_rdata = {15'h0000, timeout.minutes, timeout.ticks, 8'h00};
        `SWDT_ADDR_STATUS:   next_rdata = {28'h000_0000,
                                           state == swdt_pkg::SWDT_ST_FIRED, last_ok,
                                           state == swdt_pkg::SWDT_ST_RUN,
                                           state != swdt_pkg::SWDT_ST_IDLE};
        `SWDT_ADDR_IRQ_STAT: next_rdata = {30'h0000_0000, irq_stat};
        `SWDT_ADDR_IRQ_MASK: next_rdata = {30'h0000_0000, irq_mask};
        `SWDT_ADDR_COUNT:    next_rdata = {18'h0_0000, secs_left, ticks_left};
        default:             next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state             <= swdt_pkg::SWDT_ST_IDLE;
      timeout           <= '{ticks: 8'hFF, minutes: 1'b0};
      ticks_left        <= 8'h00;
      secs_left         <= 6'h00;
      last_ok           <= 1'b1;
      rst_cnt           <= 16'h0000;
      led               <= 1'b0;
      served            <= 1'b0;
      irq_stat          <= 2'b00;
      irq_mask          <= 2'b00;
      avs_readdata_o    <= 32'h0000_0000;
      avs_waitrequest_o <= 1'b1;
      sys_reset_o       <= 1'b0;
      led_o             <= 1'b0;
      irq_o             <= 1'b0;
    end else begin
      state             <= next_state;
      timeout           <= next_timeout;
      ticks_left        <= next_ticks_left;
      secs_left         <= next_secs_left;
      last_ok           <= next_last_ok;
      rst_cnt           <= next_rst_cnt;
      led               <= next_led;
      served            <= next_served;
      irq_stat          <= next_irq_stat;
      irq_mask          <= next_irq_mask;
      avs_readdata_o    <= next_rdata;
      avs_waitrequest_o <= !next_served;
      sys_reset_o       <= (next_state == swdt_pkg::SWDT_ST_FIRED);
      led_o             <= next_led;
      irq_o             <= |(next_irq_stat & next_irq_mask);
    end
  end

endmodule // swdt_top

// [testbench/swdt_properties.sv]
// Purpose: port-level checks of the system watchdog
// Assumes: one clock, synchronous active-low reset
// Notes: bound into swdt_top below
`timescale 1ns/1ns
module swdt_properties (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  // avalon-mm slave
  input wire logic [3:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  // system side
  input wire logic        sys_reset_o,
  input wire logic        led_o,
  input wire logic        irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_wait_one: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o) else $error("access not answered after one wait");
  a_wait_single: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low for more than one cycle");
  a_wait_idle: assert property (!avs_read_i && !avs_write_i && avs_waitrequest_o
    |=> avs_waitrequest_o) else $error("answer without a request");
  a_readdata_stands: assert property (!$stable(avs_readdata_o)
    |-> !avs_waitrequest_o && $past(avs_read_i)) else $error("read data moved outside a read");
  a_reset_quiet: assert property ($rose(rst_n_i) |-> !sys_reset_o && !led_o && !irq_o
    && avs_waitrequest_o) else $error("outputs not quiet after reset");
  a_pulse_width: assert property ($rose(sys_reset_o)
    |-> sys_reset_o[*8] ##1 sys_reset_o[*8]) else $error("system reset pulse too short");
  a_pulse_end: assert property ($rose(sys_reset_o) |-> ##[16:18] !sys_reset_o)
    else $error("system reset pulse too long");
  a_led_fired: assert property (sys_reset_o && $past(sys_reset_o, 2) |-> !led_o)
    else $error("indicator active after expiry");
endmodule // swdt_properties

bind swdt_top swdt_properties u_props (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .sys_reset_o(sys_reset_o), .led_o(led_o),
  .irq_o(irq_o));

// [testbench/test_system_watchdog_timer.sv]
// Purpose: self-checking bench of the system watchdog
// Assumes: short second of 10 clocks, minute of 2 seconds
// Notes: reads are scored against a queue of expectations
`include "swdt_consts.svh"
`timescale 1ns/1ns
module test_system_watchdog_timer;
  localparam int SEC = 10;
  localparam int MIN = 2;
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wd = 32'h0000_0000;
  logic [31:0] rdata;
  logic        wt, srst, led, irq;
  logic [31:0] rnd = 32'h0000_272F;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  logic [7:0]  t;
  int          fail_count = 0;
  int          comparisons = 0;
  int          fires = 0;
  int          flips = 0;
  logic        led_prev = 1'b0;
  int          n, f;

  always #20 clk_i = ~clk_i;

  swdt_top #(.SEC_CYCLES(SEC), .MIN_SECONDS(MIN)) dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wt), .sys_reset_o(srst), .led_o(led),
    .irq_o(irq));

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    xorshift = v ^ (v << 5);
  endfunction

  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_i);
    rd <= !w; wr <= w; addr <= a; wd <= d;
    k = 0;
    do begin @(posedge clk_i); k++; end while (wt !== 1'b0 && k < 50);
    if (k >= 50) chk("waitrequest", 32'h0, 32'h1);
    rd <= 1'b0; wr <= 1'b0;
  endtask

  task automatic rdx(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    bus(1'b0, a, 32'h0);
  endtask

  task automatic cmd(input logic [2:0] c, input logic [7:0] k, input logic [7:0] u);
    bus(1'b1, `SWDT_ADDR_CMD, {8'h00, u, k, 5'h00, c});
  endtask

  task automatic fire_time(input int e);
    n = 0;
    while (srst !== 1'b1 && n < 5000) begin @(posedge clk_i); n++; end
    chk("expiry_cycles", 32'h1, 32'(n >= e - 2 && n <= e + 3));
  endtask

  // read answers and output activity are watched here
  always @(posedge clk_i) begin
    if (srst === 1'b1) fires++;
    if (led !== led_prev) flips++;
    led_prev <= led;
    if (rd && wt === 1'b0) begin
      if (exp_q.size() == 0) chk("read_queue", 32'h0, 32'h1);
      else chk("readdata", exp_q.pop_front(), rdata & msk_q.pop_front());
    end
  end

  task automatic complete_run();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    #(40 * 40000);
    fail_count++;
    complete_run();
  end

  initial begin
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rdx(`SWDT_ADDR_STATUS, 32'h0, 32'hB);
    rdx(4'h6, 32'h0, 32'hFFFF_FFFF);
    cmd(`SWDT_CMD_START, 8'h00, 8'h00);
    rdx(`SWDT_ADDR_STATUS, 32'h0, 32'h6);
    rdx(`SWDT_ADDR_IRQ_STAT, 32'h1, 32'h1);
    bus(1'b1, `SWDT_ADDR_IRQ_STAT, 32'h1);
    rdx(`SWDT_ADDR_IRQ_STAT, 32'h0, 32'h1);
    cmd(`SWDT_CMD_INIT, 8'h00, 8'h00);
    rdx(`SWDT_ADDR_STATUS, 32'h5, 32'h7);
    bus(1'b1, `SWDT_ADDR_IRQ_MASK, 32'h3);
    rnd = xorshift(rnd);
    t = 8'(rnd % 6) + 8'h01;
    cmd(`SWDT_CMD_SET, t, `SWDT_UNIT_SEC);
    cmd(`SWDT_CMD_SET, 8'h00, `SWDT_UNIT_SEC);
    rdx(`SWDT_ADDR_STATUS, 32'h1, 32'h5);
    cmd(`SWDT_CMD_SET, 8'h05, 8'h02);
    rdx(`SWDT_ADDR_IRQ_STAT, 32'h1, 32'h1);
    rdx(`SWDT_ADDR_TIMEOUT, {16'h0000, t, 8'h00}, 32'hFFFF_FFFF);
    chk("irq_fail", 32'h1, {31'h0, irq});
    bus(1'b1, `SWDT_ADDR_IRQ_STAT, 32'h1);
    repeat (2) @(posedge clk_i);
    chk("irq_clear", 32'h0, {31'h0, irq});
    cmd(`SWDT_CMD_START, 8'h00, 8'h00);
    fire_time(int'(t) * SEC);
    rdx(`SWDT_ADDR_STATUS, 32'h8, 32'h8);
    rdx(`SWDT_ADDR_IRQ_STAT, 32'h2, 32'h2);
    chk("irq_expiry", 32'h1, {31'h0, irq});
    bus(1'b1, `SWDT_ADDR_IRQ_MASK, 32'h0);
    repeat (2) @(posedge clk_i);
    chk("irq_masked", 32'h0, {31'h0, irq});
    bus(1'b1, `SWDT_ADDR_IRQ_STAT, 32'h3);
    repeat (20) @(posedge clk_i);
    rdx(`SWDT_ADDR_STATUS, 32'h1, 32'hB);
    cmd(`SWDT_CMD_SET, 8'h02, `SWDT_UNIT_MIN);
    cmd(`SWDT_CMD_START, 8'h00, 8'h00);
    fire_time(2 * MIN * SEC);
    repeat (20) @(posedge clk_i);
    cmd(`SWDT_CMD_SET, 8'h03, `SWDT_UNIT_SEC);
    cmd(`SWDT_CMD_START, 8'h00, 8'h00);
    f = fires;
    flips = 0;
    repeat (3) begin
      repeat (18) @(posedge clk_i);
      cmd(`SWDT_CMD_RELOAD, 8'h00, 8'h00);
      rdx(`SWDT_ADDR_COUNT, 32'h3, 32'hFF);
    end
    chk("reload_no_fire", f, fires);
    chk("led_flash", 32'h1, 32'(flips > 2));
    cmd(`SWDT_CMD_STOP, 8'h00, 8'h00);
    repeat (60) @(posedge clk_i);
    chk("stop_no_fire", f, fires);
    chk("led_stopped", 32'h0, {31'h0, led});
    rdx(`SWDT_ADDR_STATUS, 32'h5, 32'h7);
    complete_run();
  end
endmodule // test_system_watchdog_timer
